/* File: logic/sync_select_edge_sense.v */
// Sync source selection, edge sense flags and module halt control
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`include "sync_select_defines.vh"
module sync_select_edge_sense (
    input wire clock,
    input wire reset_n,
    input wire hw_standby,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire vert_sync_in_pin,
    input wire horiz_sync_in_pin,
    input wire composite_sync_in_pin,
    input wire horiz_flyback_in_pin,
    input wire vert_flyback_in_pin,
    input wire internal_horiz_input,
    input wire internal_vert_input,
    input wire vert_fall_mod,
    input wire vert_horiz_sync,
    input wire vert_fall_horiz_sync,
    input wire generated_vert_signal,
    input wire generated_horiz_signal,
    input wire clamp_a,
    input wire clamp_b,
    input wire clamp_c,
    input wire clamp_d,
    input wire mask_interval,
    output reg internal_vert_output,
    output reg clamp_output_source,
    output reg internal_horiz_source,
    output reg halt_free_running_timer,
    output reg halt_timer_ch01,
    output reg halt_timer_xy_interconnect
);
    reg [7:0] source_ctrl_r;
    reg [5:0] flags_r;
    reg [5:0] flags_nxt;
    reg [5:0] seen_one_r;
    reg [15:0] halt_ctrl_r;
    reg [4:0] pin_s1_r;
    reg [4:0] pin_s2_r;
    reg [4:0] pin_s3_r;
    reg hin_prev_r;
    reg dph_valid_r;
    reg dph_write_r;
    reg [3:0] dph_addr_r;
    wire addr_phase;
    wire [4:0] pin_rise;
    wire hin_edge;
    wire wr_edge;
    wire rd_edge;
    wire bus_idle;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_phase = hsel & htrans[1] & hready;
    assign wr_edge = dph_valid_r & dph_write_r
        & (dph_addr_r == `ADDR_EDGE_SENSE);
    assign rd_edge = addr_phase & ~hwrite
        & (haddr[3:0] == `ADDR_EDGE_SENSE);
    assign bus_idle = ~dph_valid_r;

    // Pin synchroniser and rise detector
    always @(posedge clock)
    begin
        if (!reset_n)
        begin
            pin_s1_r <= 5'h00;
            pin_s2_r <= 5'h00;
            pin_s3_r <= 5'h00;
            hin_prev_r <= 1'b0;
        end
        else
        begin
            pin_s1_r <= {vert_sync_in_pin, horiz_sync_in_pin,
                composite_sync_in_pin, horiz_flyback_in_pin,
                vert_flyback_in_pin};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            hin_prev_r <= internal_horiz_input;
        end
    end
    assign pin_rise = pin_s2_r & ~pin_s3_r;
    assign hin_edge = internal_horiz_input ^ hin_prev_r;

    // Bus data phase tracking
    always @(posedge clock)
    begin
        if (!reset_n)
        begin
            dph_valid_r <= 1'b0;
            dph_write_r <= 1'b0;
            dph_addr_r <= 4'h0;
        end
        else if (hready)
        begin
            dph_valid_r <= addr_phase;
            dph_write_r <= hwrite;
            dph_addr_r <= haddr[3:0];
        end
    end

    // Flag next state: set wins over clear
    always @*
    begin
        flags_nxt = flags_r;
        if (wr_edge)
            flags_nxt = flags_r & ~(seen_one_r & ~hwdata[7:2]);
        flags_nxt[5:1] = flags_nxt[5:1] | pin_rise;
        flags_nxt[0] = flags_nxt[0] | (hin_edge & mask_interval);
    end

    always @(posedge clock)
    begin
        if (!reset_n || hw_standby)
        begin
            flags_r <= `FLAG_RESET;
            seen_one_r <= 6'h00;
            source_ctrl_r <= `SRC_RESET;
            halt_ctrl_r <= `HALT_RESET;
        end
        else
        begin
            flags_r <= flags_nxt;
            if (wr_edge)
                seen_one_r <= 6'h00;
            else if (rd_edge)
                seen_one_r <= seen_one_r | flags_r;
            if (dph_valid_r & dph_write_r)
            begin
                if (dph_addr_r == `ADDR_SOURCE_CTRL)
                    source_ctrl_r <= hwdata[7:0];
                if (dph_addr_r == `ADDR_HALT_CTRL)
                    halt_ctrl_r <= hwdata[15:0];
            end
        end
    end

    // Halt outputs update only between bus cycles
    always @(posedge clock)
    begin
        if (!reset_n || hw_standby)
        begin
            halt_free_running_timer <= 1'b1;
            halt_timer_ch01 <= 1'b1;
            halt_timer_xy_interconnect <= 1'b1;
        end
        else if (bus_idle)
        begin
            halt_free_running_timer <= halt_ctrl_r[`BIT_HALT_TIMER];
            halt_timer_ch01 <= halt_ctrl_r[`BIT_HALT_CH01];
            halt_timer_xy_interconnect <= halt_ctrl_r[`BIT_HALT_XY];
        end
    end

    // Read data
    always @(posedge clock)
    begin
        if (!reset_n)
            hrdata <= 32'h00000000;
        else if (addr_phase & ~hwrite)
        begin
            case (haddr[3:0])
                `ADDR_SOURCE_CTRL: hrdata <= {24'h000000, source_ctrl_r};
                `ADDR_EDGE_SENSE: hrdata <= {24'h000000, flags_r,
                    internal_horiz_input, internal_vert_input};
                `ADDR_HALT_CTRL: hrdata <= {16'h0000, halt_ctrl_r};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    // Source selection, registered
    always @(posedge clock)
    begin
        if (!reset_n)
        begin
            internal_vert_output <= 1'b0;
            clamp_output_source <= 1'b0;
            internal_horiz_source <= 1'b0;
        end
        else if (source_ctrl_r[`BIT_ISGEN])
        begin
            internal_vert_output <= generated_vert_signal;
            clamp_output_source <= clamp_d;
            internal_horiz_source <= generated_horiz_signal;
        end
        else
        begin
            internal_horiz_source <= internal_horiz_input;
            case (source_ctrl_r[3:2])
                2'b00: internal_vert_output <= internal_vert_input;
                2'b01: internal_vert_output <= vert_horiz_sync;
                2'b10: internal_vert_output <= vert_fall_mod;
                default: internal_vert_output <= vert_fall_horiz_sync;
            endcase
            case (source_ctrl_r[1:0])
                2'b00: clamp_output_source <= clamp_a;
                2'b01: clamp_output_source <= clamp_b;
                2'b10: clamp_output_source <= clamp_c;
                default: clamp_output_source <= 1'b0;
            endcase
        end
    end
endmodule // sync_select_edge_sense

/* File: logic/sync_select_defines.vh */
// Register map, field positions and reset values for sync select block
// Summary of operation
// - Source select 0: vert mode picks input variant
// - Source select 1, mode 00: generated vertical
// - Source select 0: clamp mode picks a/b/c
// - Source select 1, mode 00: clamp d
// - Vertical sync pin rise sets bit 7
// - Horizontal sync pin rise sets bit 6
// - Composite sync pin rise sets bit 5
// - Horizontal flyback rise sets bit 4
// - Vertical flyback rise sets bit 3
// - Flag clears by writing 0 after reading 1
// - Horizontal edge in mask sets bit 2
// - Bit 1 shows internal horizontal level
// - Bit 0 shows internal vertical level
// - Reset/standby clear six flags and source select word
// - Halt bit 13 stops free-running timer
// - Halt bit 12 stops timer channels 0/1
// - Halt bit 8 stops X/Y and unit
// - Halting waits for bus cycle end
// - Halt word resets to 3FFF on reset and on hw standby
// - Source select 1 uses generated signals
`ifndef SYNC_SELECT_DEFINES_VH
`define SYNC_SELECT_DEFINES_VH
`define ADDR_SOURCE_CTRL 4'h0
`define ADDR_EDGE_SENSE 4'h4
`define ADDR_HALT_CTRL 4'h8
`define SRC_RESET 8'h00
`define HALT_RESET 16'h3FFF
`define FLAG_RESET 6'h00
`define BIT_ISGEN 6
`define BIT_HALT_TIMER 13
`define BIT_HALT_CH01 12
`define BIT_HALT_XY 8
`define FLAG_MSB 7
`define FLAG_LSB 2
`define BIT_HLEVEL 1
`define BIT_VLEVEL 0
`endif

/* File: bench/sync_select_chk.sv */
// Port checker for the sync select block
module sync_select_chk (
    input wire clock, reset_n, hw_standby, hsel, hwrite, hready, hresp,
    input wire [31:0] haddr, hwdata, hrdata,
    input wire [1:0] htrans,
    input wire hreadyout, internal_vert_input, vert_fall_mod,
    input wire vert_horiz_sync, vert_fall_horiz_sync, generated_vert_signal,
    input wire clamp_a, clamp_b, clamp_c, clamp_d, internal_vert_output,
    input wire clamp_output_source, halt_free_running_timer,
    input wire halt_timer_ch01, halt_timer_xy_interconnect,
    input wire internal_horiz_input, generated_horiz_signal,
    input wire internal_horiz_source
);
    timeunit 1ns;
    timeprecision 1ps;
    reg p_r;
    reg [2:0] a_r;
    reg [7:0] src_r;
    reg [2:0] hw_r;
    wire clr = !reset_n || hw_standby;
    wire [2:0] hl = {halt_free_running_timer, halt_timer_ch01,
        halt_timer_xy_interconnect};
    wire [3:0] vs = {vert_fall_horiz_sync, vert_fall_mod, vert_horiz_sync,
        internal_vert_input};
    wire [3:0] cs = {1'h0, clamp_c, clamp_b, clamp_a};
    wire ev = src_r[6] ? generated_vert_signal : vs[src_r[3:2]];
    wire ec = src_r[6] ? clamp_d : cs[src_r[1:0]];
    wire eh = src_r[6] ? generated_horiz_signal : internal_horiz_input;
    always @(posedge clock)
    begin
        p_r <= !clr && hsel && htrans[1] && hready;
        a_r <= {hwrite, haddr[3:2]};
        if (clr)
            src_r <= 8'h00;
        else if (p_r && a_r == 3'h4)
            src_r <= hwdata[7:0];
        if (clr)
            hw_r <= 3'h7;
        else if (p_r && a_r == 3'h6)
            hw_r <= {hwdata[13:12], hwdata[8]};
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_vert_out_map: assert property (!hw_standby |=>
        internal_vert_output == $past(ev)) else $error("vert source");
    a_clamp_src_map: assert property (!hw_standby |=>
        clamp_output_source == $past(ec)) else $error("clamp source");
    a_horiz_src_map: assert property (!hw_standby |=>
        internal_horiz_source == $past(eh)) else $error("horiz source");
    a_halt_reset_val: assert property ($rose(reset_n) ||
        $past(hw_standby) |-> hl == 3'h7) else $error("halt reset");
    a_halt_follow_word: assert property (!p_r && !hw_standby |=>
        hl == $past(hw_r)) else $error("halt word");
    a_halt_bus_end: assert property (p_r |=> $stable(hl))
        else $error("halt in access");
    a_rdata_reset: assert property ($rose(reset_n) |-> hrdata == 32'h0)
        else $error("rdata reset");
    a_resp_okay: assert property (hresp == 1'h0) else $error("resp");
    a_ready_zero_wait: assert property (hreadyout == 1'h1)
        else $error("ready");
endmodule // sync_select_chk
bind sync_select_edge_sense sync_select_chk chk (.*);

/* File: bench/sync_pin_model.sv */
// Pulse source for the sync and flyback pins
module sync_pin_model (
    input wire clock,
    input wire [4:0] pulse_req,
    output logic [4:0] pins = 5'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] held_r = 5'h00;
    always @(posedge clock)
    begin
        pins <= pulse_req | held_r;
        held_r <= pulse_req;
    end
endmodule // sync_pin_model

/* File: bench/sync_select_edge_sense_tb_top.sv */
// Self-checking bench for the sync select block
module sync_select_edge_sense_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, reset_n = 0, hw_standby = 0, hwrite = 0, ih = 0;
    logic iv = 0, mk = 0, hreadyout;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
    logic [8:0] s = 0;
    logic [4:0] req = 0, p;
    logic [2:0] h;
    logic vo, co, ho;
    int error_cnt = 0, checks_done = 0;
    always #2 clock = ~clock;
    always @(posedge clock) s <= s + 9'h1;
    sync_pin_model pm (.clock, .pulse_req(req), .pins(p));
    sync_select_edge_sense dut (.clock, .reset_n, .hw_standby, .hsel(1'h1),
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hreadyout, .hresp(), .hrdata, .vert_sync_in_pin(p[4]),
        .horiz_sync_in_pin(p[3]), .composite_sync_in_pin(p[2]),
        .horiz_flyback_in_pin(p[1]), .vert_flyback_in_pin(p[0]),
        .internal_horiz_input(ih), .internal_vert_input(iv),
        .vert_fall_mod(s[0]), .vert_horiz_sync(s[1]),
        .vert_fall_horiz_sync(s[2]), .generated_vert_signal(s[3]),
        .generated_horiz_signal(s[4]), .clamp_a(s[5]), .clamp_b(s[6]),
        .clamp_c(s[7]), .clamp_d(s[8]), .mask_interval(mk),
        .internal_vert_output(vo), .clamp_output_source(co),
        .internal_horiz_source(ho), .halt_free_running_timer(h[2]),
        .halt_timer_ch01(h[1]), .halt_timer_xy_interconnect(h[0]));
    task cmp(input [31:0] got, input [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task xfer(input [3:0] a, input w, input [31:0] d);
        haddr <= {28'h0, a}; hwrite <= w; htrans <= 2'h2;
        do @(posedge clock); while (hreadyout !== 1'h1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'h1);
        q = hrdata;
    endtask
    task rdc(input [3:0] a, input [31:0] exp);
        xfer(a, 1'h0, 32'h0); cmp(q, exp);
    endtask
    task pulse(input [4:0] r);
        req <= r; @(posedge clock); req <= 5'h0; repeat (6) @(posedge clock);
    endtask
    task t_reset;
        rdc(4'h8, 32'h3FFF);
        rdc(4'h4, 32'h0);
        rdc(4'hC, 32'h0);
        cmp(h, 3'h7);
    endtask
    task t_edges;
        mk <= 1'h1; ih <= 1'h1; pulse(5'h1F); mk <= 1'h0;
        rdc(4'h4, 32'hFE);
        xfer(4'h4, 1'h1, 32'hFF);
        rdc(4'h4, 32'hFE);
        xfer(4'h4, 1'h1, 32'h0);
        rdc(4'h4, 32'h2);
        iv <= 1'h1; pulse(5'h10); xfer(4'h4, 1'h1, 32'h0);
        rdc(4'h4, 32'h83);
        mk <= 1'h1;
        ih <= 1'h0;
        @(posedge clock);
        mk <= 1'h0;
        ih <= 1'h1;
        rdc(4'h4, 32'h87);
    endtask
    task t_select;
        logic [7:0] m[5] = '{8'h05, 8'h0A, 8'h0F, 8'h40, 8'h00};
        logic [8:0] v;
        logic ev, ec, eh;
        foreach (m[i])
        begin
            xfer(4'h0, 1'h1, {24'h0, m[i]});
            rdc(4'h0, {24'h0, m[i]});
            repeat (4)
            begin
                @(negedge clock);
                v = s - 9'h1;
                case (m[i][3:2])
                    2'h0: ev = iv;
                    2'h1: ev = v[1];
                    2'h2: ev = v[0];
                    default: ev = v[2];
                endcase
                case (m[i][1:0])
                    2'h0: ec = v[5];
                    2'h1: ec = v[6];
                    2'h2: ec = v[7];
                    default: ec = 1'h0;
                endcase
                eh = ih;
                if (m[i][6])
                begin
                    ev = v[3];
                    ec = v[8];
                    eh = v[4];
                end
                cmp({vo, co, ho}, {ev, ec, eh});
            end
            @(posedge clock);
        end
    endtask
    task t_halt;
        xfer(4'h8, 1'h1, 32'h0);
        rdc(4'h8, 32'h0);
        cmp(h, 3'h0);
        hw_standby <= 1'h1; @(posedge clock); hw_standby <= 1'h0;
        @(posedge clock);
        cmp(h, 3'h7);
        rdc(4'h8, 32'h3FFF);
        rdc(4'h4, 32'h3);
    endtask
    task summarize;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clock);
        reset_n <= 1'h1;
        @(posedge clock);
        t_reset; t_edges; t_select; t_halt; summarize;
    end
    initial
    begin
        repeat (2000) @(posedge clock);
        error_cnt++; summarize;
    end
endmodule // sync_select_edge_sense_tb_top
